// >>> rtl/clk_synth_ctrl.sv
// Digital control of a frequency synthesis loop: dividers, switchover, reconfiguration
`timescale 1ns/1ps
module clk_synth_ctrl #(
    parameter int RELOCK_CYCLES = clk_synth_pkg::RELOCK_CYC,
    parameter int NUM_OUT       = clk_synth_pkg::NUM_OUT
) (
    input  wire logic                                  clk_in,
    input  wire logic                                  rst_in,
    input  wire logic                                  primary_ref_input,
    input  wire logic                                  secondary_ref_input,
    input  wire logic                                  auto_switch_en_in,
    input  wire logic                                  manual_switch_in,
    input  wire logic                                  shift_clk_in,
    input  wire logic                                  shift_data_in,
    input  wire logic                                  shift_clear_in,
    input  wire logic                                  shift_last_in,
    input  wire logic [clk_synth_pkg::BW_W-1:0]        bandwidth_sel_in,
    output logic                                       ref_sel_out,
    output logic                                       ref_clk_out,
    output logic                                       locked_out,
    output logic                                       primary_bad_out,
    output logic                                       cfg_error_out,
    output logic [clk_synth_pkg::CNT_W-1:0]            pre_div_out,
    output logic [clk_synth_pkg::CNT_W-1:0]            mult_out,
    output logic [clk_synth_pkg::BW_W-1:0]             bandwidth_out,
    output logic [NUM_OUT*clk_synth_pkg::CNT_W-1:0]    post_div_out,
    output logic [NUM_OUT-1:0]                         odd_duty_out,
    output logic [NUM_OUT*clk_synth_pkg::DLY_W-1:0]    delay_out,
    output logic [NUM_OUT-1:0]                         out_clk_out
);
    localparam int CW = clk_synth_pkg::CNT_W;
    localparam int DW = clk_synth_pkg::DLY_W;
    localparam int SW = CW + 1 + DW;
    localparam int CHAIN = 2 * CW + NUM_OUT * SW;

    // Range check shared by pre/mult and post counters
    function automatic logic in_range(input logic [CW-1:0] v, input logic [CW-1:0] lim);
        in_range = (v != '0) && (v <= lim);
    endfunction

    // ---------------- Reference sensing and switchover ----------------
    logic              primary_alive;
    logic              secondary_alive;
    clk_synth_pkg::sw_state_t sw_q;
    clk_synth_pkg::sw_state_t sw_d;
    logic              man_q;
    logic              man_rise;
    logic              sel_q;
    logic              sel_sync1_q;
    logic              sel_sync2_q;

    edge_sense #(.TIMEOUT(clk_synth_pkg::LOSS_CYC)) u_sense_pri (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ref_in    (primary_ref_input),
        .alive_out (primary_alive)
    );

    edge_sense #(.TIMEOUT(clk_synth_pkg::LOSS_CYC)) u_sense_sec (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ref_in    (secondary_ref_input),
        .alive_out (secondary_alive)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            man_q <= 1'b0;
        end else begin
            man_q <= manual_switch_in;
        end
    end
    assign man_rise = manual_switch_in & ~man_q;

    // Manual request toggles the reference; automatic mode leaves a dead primary
    always_comb begin
        sw_d = sw_q;
        case (sw_q)
            clk_synth_pkg::SW_PRIMARY: begin
                if (man_rise) begin
                    sw_d = clk_synth_pkg::SW_HOLD;
                end else if (auto_switch_en_in && !primary_alive && secondary_alive) begin
                    sw_d = clk_synth_pkg::SW_HOLD;
                end
            end
            clk_synth_pkg::SW_HOLD: begin
                sw_d = sel_q ? clk_synth_pkg::SW_PRIMARY : clk_synth_pkg::SW_SECONDARY;
            end
            clk_synth_pkg::SW_SECONDARY: begin
                if (man_rise) begin
                    sw_d = clk_synth_pkg::SW_HOLD;
                end
            end
            default: sw_d = clk_synth_pkg::SW_PRIMARY;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sw_q  <= clk_synth_pkg::SW_PRIMARY;
            sel_q <= 1'b0;
        end else begin
            sw_q <= sw_d;
            if (sw_q == clk_synth_pkg::SW_HOLD) begin
                sel_q <= ~sel_q;
            end
        end
    end

    // Select is resynchronised into each reference's low phase so neither
    // input is cut short: a classic break-before-make mux.
    logic pri_en1_q;
    logic pri_en2_q;
    logic sec_en1_q;
    logic sec_en2_q;
    logic pri_gone_q;
    logic pri_off1_q;
    logic pri_off2_q;

    always_ff @(negedge primary_ref_input or posedge rst_in) begin
        if (rst_in) begin
            pri_en1_q <= 1'b1;
            pri_en2_q <= 1'b1;
        end else begin
            pri_en1_q <= ~sel_q & ~sec_en2_q;
            pri_en2_q <= pri_en1_q;
        end
    end

    always_ff @(negedge secondary_ref_input or posedge rst_in) begin
        if (rst_in) begin
            sec_en1_q <= 1'b0;
            sec_en2_q <= 1'b0;
        end else begin
            sec_en1_q <= sel_q & (~pri_en2_q | pri_gone_q);
            sec_en2_q <= sec_en1_q;
        end
    end

    // A stopped primary cannot clock its own enable low, so it is fenced off
    // here instead; the fence lifts only once that enable has really dropped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pri_off1_q <= 1'b0;
            pri_off2_q <= 1'b0;
            pri_gone_q <= 1'b0;
        end else begin
            pri_off1_q <= ~pri_en2_q;
            pri_off2_q <= pri_off1_q;
            if (sel_q && !primary_alive) begin
                pri_gone_q <= 1'b1;
            end else if (pri_off2_q) begin
                pri_gone_q <= 1'b0;
            end
        end
    end

    assign ref_clk_out = (primary_ref_input & pri_en2_q & ~pri_gone_q)
                       | (secondary_ref_input & sec_en2_q);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_sync1_q <= 1'b0;
            sel_sync2_q <= 1'b0;
        end else begin
            sel_sync1_q <= sec_en2_q;
            sel_sync2_q <= sel_sync1_q;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_sel_out     <= 1'b0;
            primary_bad_out <= 1'b0;
        end else begin
            ref_sel_out     <= sel_sync2_q;
            primary_bad_out <= ~primary_alive;
        end
    end

    // ---------------- Serial reconfiguration chain ----------------
    // Chain order, first bit shifted lands deepest: pre, mult, then per output
    // {post count, odd duty, delay}. Loop filter and phase taps have no slot.
    logic [CHAIN-1:0] chain_q;
    logic             load_tgl_q;

    always_ff @(posedge shift_clk_in or posedge shift_clear_in) begin
        if (shift_clear_in) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[CHAIN-2:0], shift_data_in};
        end
    end

    // Completion toggle ignores the chain clear, so a clear cannot fake a load
    always_ff @(posedge shift_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_tgl_q <= 1'b0;
        end else if (shift_last_in) begin
            load_tgl_q <= ~load_tgl_q;
        end
    end

    logic ld1_q;
    logic ld2_q;
    logic ld3_q;
    logic load_now;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ld1_q <= 1'b0;
            ld2_q <= 1'b0;
            ld3_q <= 1'b0;
        end else begin
            ld1_q <= load_tgl_q;
            ld2_q <= ld1_q;
            ld3_q <= ld2_q;
        end
    end
    // Chain stays still after the last bit, so it is stable when sampled here
    assign load_now = ld2_q ^ ld3_q;

    logic [CW-1:0] new_pre;
    logic [CW-1:0] new_mult;
    logic          new_ok;

    assign new_pre  = chain_q[CHAIN-1 -: CW];
    assign new_mult = chain_q[CHAIN-CW-1 -: CW];

    logic [NUM_OUT-1:0] slot_ok;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_slot
            localparam int BASE = (NUM_OUT - 1 - gi) * SW;
            logic [CW-1:0] cnt_v;
            logic          odd_v;
            assign cnt_v = chain_q[BASE + SW - 1 -: CW];
            assign odd_v = chain_q[BASE + DW];
            assign slot_ok[gi] = in_range(cnt_v, odd_v ? clk_synth_pkg::POST_MAXNF
                                                       : clk_synth_pkg::POST_MAX50);

            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    post_div_out[gi*CW +: CW] <= clk_synth_pkg::CNT_RST;
                    odd_duty_out[gi]          <= 1'b0;
                    delay_out[gi*DW +: DW]    <= clk_synth_pkg::DLY_RST;
                end else if (load_now && new_ok) begin
                    post_div_out[gi*CW +: CW] <= cnt_v;
                    odd_duty_out[gi]          <= odd_v;
                    delay_out[gi*DW +: DW]    <= chain_q[BASE +: DW];
                end
            end

            // Post-scale divider of the oscillator stand-in (system clock)
            logic [CW-1:0] div_q;
            logic          oc_q;
            logic [CW-1:0] half;
            assign half = odd_duty_out[gi] ? CW'(1)
                                           : (post_div_out[gi*CW +: CW] >> 1);
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    div_q <= '0;
                    oc_q  <= 1'b0;
                end else begin
                    if (div_q + CW'(1) >= post_div_out[gi*CW +: CW]) begin
                        div_q <= '0;
                    end else begin
                        div_q <= div_q + CW'(1);
                    end
                    oc_q <= (post_div_out[gi*CW +: CW] == CW'(1)) ? ~oc_q : (div_q < half);
                end
            end
            assign out_clk_out[gi] = oc_q;
        end
    endgenerate

    // Whole chain is accepted or rejected, never partially applied
    assign new_ok = in_range(new_pre, clk_synth_pkg::PRE_MAX)
                  & in_range(new_mult, clk_synth_pkg::PRE_MAX)
                  & (&slot_ok);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_div_out   <= clk_synth_pkg::CNT_RST;
            mult_out      <= clk_synth_pkg::CNT_RST;
            cfg_error_out <= 1'b0;
        end else if (load_now) begin
            cfg_error_out <= ~new_ok;
            if (new_ok) begin
                pre_div_out <= new_pre;
                mult_out    <= new_mult;
            end
        end
    end

    // Bandwidth is a static option, picked up only while the loop relocks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bandwidth_out <= clk_synth_pkg::BW_RST;
        end else if (!locked_out) begin
            bandwidth_out <= bandwidth_sel_in;
        end
    end

    // ---------------- Lock indication ----------------
    logic [31:0] relock_q;
    logic        disturb;
    logic        sel_prev_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_q;
        end
    end

    assign disturb = (sel_q != sel_prev_q) || (load_now && new_ok)
                   || (sel_q != ref_sel_out)
                   || (sel_q ? !secondary_alive : !primary_alive);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            relock_q   <= '0;
            locked_out <= 1'b0;
        end else if (disturb) begin
            relock_q   <= '0;
            locked_out <= 1'b0;
        end else if (relock_q < 32'(RELOCK_CYCLES)) begin
            relock_q   <= relock_q + 32'h00000001;
        end else begin
            locked_out <= 1'b1;
        end
    end
endmodule // clk_synth_ctrl

// >>> rtl/clk_synth_pkg.sv
// Constants shared by the clock synthesis control block
package clk_synth_pkg;
    localparam int CNT_W            = 11;
    localparam logic [10:0] PRE_MAX    = 11'h200;
    localparam logic [10:0] POST_MAX50 = 11'h400;
    localparam logic [10:0] POST_MAXNF = 11'h200;
    localparam logic [10:0] CNT_RST    = 11'h001;
    localparam int NUM_REGIONAL     = 2;
    localparam int NUM_GLOBAL       = 4;
    localparam int NUM_EXTERNAL     = 4;
    localparam int NUM_OUT          = NUM_REGIONAL + NUM_GLOBAL + NUM_EXTERNAL;
    localparam int DLY_W            = 4;
    localparam logic [3:0] DLY_RST  = 4'h0;
    localparam int SLOT_W           = CNT_W + 1 + DLY_W;
    localparam int CHAIN_LEN        = 2 * CNT_W + NUM_OUT * SLOT_W;
    localparam int CLK_MHZ          = 50;
    localparam int RELOCK_US        = 100;
    localparam int RELOCK_CYC       = RELOCK_US * CLK_MHZ;
    localparam int LOSS_NS          = 400;
    localparam int LOSS_CYC         = LOSS_NS * CLK_MHZ / 1000;
    localparam int BW_W             = 3;
    localparam logic [2:0] BW_RST   = 3'h0;
    typedef enum logic [1:0] {SW_PRIMARY, SW_HOLD, SW_SECONDARY} sw_state_t;
endpackage

// >>> rtl/edge_sense.sv
// Activity detector for one reference clock sampled in the system domain
`timescale 1ns/1ps
module edge_sense #(
    parameter int TIMEOUT = 20
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ref_in,
    output logic      alive_out
);
    logic       s1_q;
    logic       s2_q;
    logic       s3_q;
    logic [15:0] idle_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= ref_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Any edge restarts the idle count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_q <= 16'h0000;
        end else if (s2_q != s3_q) begin
            idle_q <= 16'h0000;
        end else if (idle_q != 16'(TIMEOUT)) begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    assign alive_out = (idle_q != 16'(TIMEOUT));
endmodule // edge_sense

// >>> testbench/chain_source.sv
// Far-side model driving the reconfiguration chain and the manual switch request
`timescale 1ns/1ps
module chain_source (
    input  wire logic clk_in,
    output logic      shift_clk_out,
    output logic      shift_data_out,
    output logic      shift_clear_out,
    output logic      shift_last_out,
    output logic      manual_switch_out
);
    initial begin
        shift_clk_out = 1'b0;
        shift_data_out = 1'b0;
        shift_clear_out = 1'b0;
        shift_last_out = 1'b0;
        manual_switch_out = 1'b0;
    end
    // About 22 MHz; clock stands low between frames, data line is inverted when idle
    task automatic send(input logic [clk_synth_pkg::CHAIN_LEN-1:0] v, input int first,
                        input int count, input logic last);
        for (int i = first; i > first - count; i--) begin
            shift_data_out = v[i];
            shift_last_out = last && (i == first - count + 1);
            #23 shift_clk_out = 1'b1;
            #23 shift_clk_out = 1'b0;
        end
        shift_data_out = ~shift_data_out;
        shift_last_out = 1'b0;
    endtask
    task automatic clear();
        #10 shift_clear_out = 1'b1;
        #20 shift_clear_out = 1'b0;
        #10;
    endtask
    task automatic toggle();
        @(negedge clk_in) manual_switch_out = 1'b1;
        repeat (4) @(negedge clk_in);
        manual_switch_out = 1'b0;
    endtask
endmodule // chain_source

// >>> testbench/clk_synth_ctrl_asserts.sv
// Concurrent checks on the clock synthesis control ports
`timescale 1ns/1ps
module clk_synth_ctrl_asserts #(
    parameter int RELOCK_CYCLES = 50,
    parameter int NUM_OUT       = clk_synth_pkg::NUM_OUT
) (
    input wire logic                                    clk_in,
    input wire logic                                    rst_in,
    input wire logic                                    primary_ref_input,
    input wire logic                                    secondary_ref_input,
    input wire logic                                    auto_switch_en_in,
    input wire logic                                    ref_sel_out,
    input wire logic                                    ref_clk_out,
    input wire logic                                    locked_out,
    input wire logic                                    primary_bad_out,
    input wire logic                                    cfg_error_out,
    input wire logic [clk_synth_pkg::CNT_W-1:0]         pre_div_out,
    input wire logic [clk_synth_pkg::CNT_W-1:0]         mult_out,
    input wire logic [clk_synth_pkg::BW_W-1:0]          bandwidth_out,
    input wire logic [NUM_OUT*clk_synth_pkg::CNT_W-1:0] post_div_out,
    input wire logic [NUM_OUT-1:0]                      odd_duty_out
);
    localparam int W = clk_synth_pkg::CNT_W;
    logic [5:0] idle_q;
    logic       prev_q;
    int         unlock_q;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // Cycles the primary reference has held one level, saturating
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_q <= 6'h00;
            prev_q <= 1'b0;
        end else begin
            prev_q <= primary_ref_input;
            idle_q <= (primary_ref_input != prev_q) ? 6'h00
                    : (idle_q == 6'h3F ? idle_q : idle_q + 6'h01);
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) unlock_q <= 0;
        else unlock_q <= locked_out ? 0 : unlock_q + 1;
    end
    pre_range_a: assert property (pre_div_out != 0 && pre_div_out <= 11'h200)
        else $error("pre-divider out of range");
    mult_range_a: assert property (mult_out != 0 && mult_out <= 11'h200)
        else $error("multiplier out of range");
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_slot
        post_range_a: assert property (post_div_out[i*W+:W] != 0 &&
            post_div_out[i*W+:W] <= (odd_duty_out[i] ? 11'h200 : 11'h400))
            else $error("post divider out of range");
    end
    loss_flag_a: assert property (idle_q >= 28 |-> primary_bad_out)
        else $error("idle primary not flagged");
    auto_switch_a: assert property (primary_bad_out && auto_switch_en_in && !ref_sel_out
        |-> ##[1:100] ref_sel_out) else $error("automatic switchover missing");
    relock_time_a: assert property (unlock_q <= RELOCK_CYCLES + 150)
        else $error("relock took too long");
    sel_unlock_a: assert property ($changed(ref_sel_out) |-> !locked_out)
        else $error("lock held across switchover");
    load_unlock_a: assert property ($changed(mult_out) |-> ##[0:2] !locked_out)
        else $error("lock held across reload");
    load_ok_a: assert property ($changed(pre_div_out) || $changed(mult_out) |-> !cfg_error_out)
        else $error("settings changed on rejected load");
    bw_hold_a: assert property ($changed(bandwidth_out) |-> !$past(locked_out))
        else $error("bandwidth changed while locked");
    clk_path_a: assert property (locked_out |->
        ref_clk_out == (ref_sel_out ? secondary_ref_input : primary_ref_input))
        else $error("reference path does not follow select");
endmodule // clk_synth_ctrl_asserts

bind clk_synth_ctrl clk_synth_ctrl_asserts #(.RELOCK_CYCLES(RELOCK_CYCLES), .NUM_OUT(NUM_OUT)) u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .primary_ref_input(primary_ref_input),
    .secondary_ref_input(secondary_ref_input), .auto_switch_en_in(auto_switch_en_in),
    .ref_sel_out(ref_sel_out), .ref_clk_out(ref_clk_out), .locked_out(locked_out),
    .primary_bad_out(primary_bad_out), .cfg_error_out(cfg_error_out),
    .pre_div_out(pre_div_out), .mult_out(mult_out), .bandwidth_out(bandwidth_out),
    .post_div_out(post_div_out), .odd_duty_out(odd_duty_out));

// >>> testbench/pll_clock_synth_switchover_reconfig_bench.sv
// Self-checking bench for the clock synthesis control block
`timescale 1ns/1ps
module pll_clock_synth_switchover_reconfig_bench;
    localparam int N = clk_synth_pkg::NUM_OUT;
    localparam int W = clk_synth_pkg::CNT_W;
    logic           clk_in = 1'b0;
    logic           rst_in = 1'b1;
    logic           pri_clk = 1'b0;
    logic           sec_clk = 1'b0;
    logic           pri_run = 1'b1;
    logic           auto_en = 1'b0;
    logic [2:0]     bw_sel = 3'h0;
    logic           sh_clk, sh_data, sh_clear, sh_last, man_sw;
    logic           ref_sel, ref_clk, locked, pri_bad, cfg_err;
    logic [W-1:0]   pre_div, mult;
    logic [2:0]     bw;
    logic [N*W-1:0] post_div;
    logic [N-1:0]   odd_duty, out_clk;
    logic [N*4-1:0] dly;
    logic [31:0]    lfsr_q = 32'h81615972;
    int fail_count = 0;
    int checks = 0;
    int cnt = 0;
    int v_pre, v_mult, v_post[N], v_odd[N], v_dly[N];
    int e_pre = 1, e_mult = 1, e_post[N], e_odd[N], e_dly[N];

    always #10 clk_in = ~clk_in;
    // Equal-frequency references, a fifth of a period apart, so automatic sensing applies
    always @(negedge clk_in) begin
        cnt <= (cnt == 4) ? 0 : cnt + 1;
        if (cnt == 0 && pri_run) pri_clk <= ~pri_clk;
        if (cnt == 2) sec_clk <= ~sec_clk;
    end

    chain_source src (.clk_in(clk_in), .shift_clk_out(sh_clk), .shift_data_out(sh_data),
        .shift_clear_out(sh_clear), .shift_last_out(sh_last), .manual_switch_out(man_sw));
    clk_synth_ctrl #(.RELOCK_CYCLES(50), .NUM_OUT(N)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .primary_ref_input(pri_clk), .secondary_ref_input(sec_clk),
        .auto_switch_en_in(auto_en), .manual_switch_in(man_sw), .shift_clk_in(sh_clk),
        .shift_data_in(sh_data), .shift_clear_in(sh_clear), .shift_last_in(sh_last),
        .bandwidth_sel_in(bw_sel), .ref_sel_out(ref_sel), .ref_clk_out(ref_clk),
        .locked_out(locked), .primary_bad_out(pri_bad), .cfg_error_out(cfg_err),
        .pre_div_out(pre_div), .mult_out(mult), .bandwidth_out(bw), .post_div_out(post_div),
        .odd_duty_out(odd_duty), .delay_out(dly), .out_clk_out(out_clk));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic int rnd(input int m);
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return int'(lfsr_q[15:0]) % m;
    endfunction
    function automatic logic [clk_synth_pkg::CHAIN_LEN-1:0] pack();
        logic [clk_synth_pkg::CHAIN_LEN-1:0] v;
        v = {v_pre[10:0], v_mult[10:0], 160'h0};
        for (int i = 0; i < N; i++) v[159-16*i -: 16] = {v_post[i][10:0], v_odd[i][0], v_dly[i][3:0]};
        return v;
    endfunction
    task automatic compare(input logic ok);
        check(cfg_err, !ok);
        check(pre_div, e_pre);
        check(mult, e_mult);
        for (int i = 0; i < N; i++) begin
            check(post_div[i*W+:W], e_post[i]);
            check(odd_duty[i], e_odd[i]);
            check(dly[i*4+:4], e_dly[i]);
        end
        if (ok) check(bw, bw_sel);
    endtask
    task automatic wait_lock();
        for (int i = 0; i < 400 && locked !== 1'b1; i++) @(negedge clk_in);
        check(locked, 1'b1);
    endtask
    // Period of the first divided output whose divider is above one
    task automatic check_period();
        int   s;
        int   n;
        int   t;
        logic p;
        s = 0;
        for (int i = N - 1; i >= 0; i--) if (e_post[i] > 1) s = i;
        n = 0;
        t = 0;
        p = out_clk[s];
        while (t < 2 && n < 4000) begin
            @(negedge clk_in);
            if (t == 1) n++;
            if (out_clk[s] && !p) t++;
            p = out_clk[s];
        end
        check(n, e_post[s]);
    endtask
    task automatic wait_sel(input logic s);
        for (int i = 0; i < 100 && ref_sel !== s; i++) @(negedge clk_in);
        check(ref_sel, s);
    endtask
    task automatic do_load(input int b);
        logic ok;
        time  t0;
        ok = v_pre inside {[1:512]} && v_mult inside {[1:512]};
        for (int i = 0; i < N; i++) ok &= v_post[i] >= 1 && v_post[i] <= (v_odd[i] ? 512 : 1024);
        if (ok) begin
            e_pre = v_pre;
            e_mult = v_mult;
            e_post = v_post;
            e_odd = v_odd;
            e_dly = v_dly;
        end
        @(negedge clk_in) bw_sel = b[2:0];
        t0 = $time;
        src.send(pack(), 181, 182, 1'b1);
        repeat (6) @(negedge clk_in);
        check($time - t0 < 20000, 1'b1);
        compare(ok);
        wait_lock();
    endtask

    initial begin
        #(400_000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        foreach (e_post[i]) e_post[i] = 1;
        foreach (e_odd[i]) e_odd[i] = 0;
        foreach (e_dly[i]) e_dly[i] = 0;
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        compare(1'b1);
        check(ref_sel, 1'b0);
        wait_lock();
        // Boundaries first, then refusals, then random settings
        for (int k = 0; k < 10; k++) begin
            v_pre = rnd(512) + 1;
            v_mult = rnd(512) + 1;
            for (int i = 0; i < N; i++) begin
                v_odd[i] = rnd(2);
                v_post[i] = rnd(v_odd[i] ? 512 : 1024) + 1;
                v_dly[i] = rnd(16);
            end
            if (k < 2) begin
                v_pre = k ? 1 : 512;
                v_mult = v_pre;
                foreach (v_odd[i]) v_odd[i] = k;
                foreach (v_post[i]) v_post[i] = k ? 512 : 1024;
            end
            if (k == 2) v_pre = 0;
            if (k == 3) v_mult = 513;
            if (k == 4) v_post[9] = v_odd[9] ? 513 : 1025;
            if (k == 5) v_post[3] = 0;
            do_load(rnd(8));
        end
        // Cleared chain mid-frame leaves zeros in the leading fields
        src.send(pack(), 181, 70, 1'b0);
        src.clear();
        src.send(pack(), 111, 112, 1'b1);
        repeat (6) @(negedge clk_in);
        compare(1'b0);
        check_period();
        do_load(rnd(8));
        @(negedge clk_in) bw_sel = 3'h5;
        src.toggle();
        wait_sel(1'b1);
        check(locked, 1'b0);
        wait_lock();
        check(bw, 3'h5);
        src.toggle();
        wait_sel(1'b0);
        wait_lock();
        pri_run = 1'b0;
        repeat (40) @(negedge clk_in);
        check(pri_bad, 1'b1);
        check(ref_sel, 1'b0);
        pri_run = 1'b1;
        wait_lock();
        auto_en = 1'b1;
        pri_run = 1'b0;
        wait_sel(1'b1);
        wait_lock();
        pri_run = 1'b1;
        repeat (40) @(negedge clk_in);
        check(ref_sel, 1'b1);
        check(locked, 1'b1);
        end_of_test();
    end
endmodule // pll_clock_synth_switchover_reconfig_bench
